// >>> logic/ssb_pkg.sv
// Package of constants and types for the serial burst slave port
package ssb_pkg;
    // ------------------------------------------------------------
    // Word and control word layout
    // ------------------------------------------------------------
    localparam int WORD_W = 16;
    localparam int ADDR_W = 10;
    localparam int CNT_W = 5;
    localparam int CTRL_RW_BIT = 15;
    localparam int CTRL_ADDR_MSB = 14;
    localparam int CTRL_ADDR_LSB = 5;
    localparam int CTRL_CNT_MSB = 4;
    localparam int CTRL_CNT_LSB = 0;
    localparam logic [3:0] BIT_LAST = 4'hf;
    // ------------------------------------------------------------
    // Status word returned while a command word arrives
    // ------------------------------------------------------------
    localparam logic [12:0] CHECK_PATTERN = 13'h1555;
    localparam int STAT_CLK_BIT = 2;
    localparam int STAT_FRAME_BIT = 1;
    localparam int STAT_WORD_BIT = 0;
    // ------------------------------------------------------------
    // Setup register
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] SETUP_ADDR = 10'h01c8;
    localparam logic [WORD_W-1:0] SETUP_RESET = 16'h000a;
    localparam logic [WORD_W-1:0] SETUP_MASK = 16'h00ff;
    localparam int SETUP_SLEW_BIT = 7;
    localparam int SETUP_MODE_BIT = 6;
    localparam int SETUP_IRQEN_BIT = 5;
    localparam int SETUP_WD_MSB = 4;
    localparam int SETUP_WD_LSB = 0;
    localparam logic MODE_A = 1'b0;
    localparam logic MODE_B = 1'b1;
    // ------------------------------------------------------------
    // Watchdog timing
    // ------------------------------------------------------------
    localparam int WD_UNIT_CYCLES = 32768;
    localparam int WD_CNT_W = 21;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [WORD_W-1:0] word;
        logic done;
        logic cs_rise;
        logic frag;
        logic cs_low;
    } ssb_rx_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_FETCH = 4'b0010,
        ST_LOAD = 4'b0100,
        ST_DATA = 4'b1000
    } ssb_state_t;
endpackage

// >>> logic/ssb_shift.sv
// Pin synchroniser and 16-bit shifter of the serial burst slave port
`timescale 1ns/100ps
module ssb_shift (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic sclk,
    input wire logic csn,
    input wire logic mosi,
    input wire logic tx_load,
    input wire logic [15:0] tx_word,
    output ssb_pkg::ssb_rx_t rx,
    output logic miso,
    output logic miso_oe
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [2:0] sclk_ff, nxt_sclk;
    logic [2:0] csn_ff, nxt_csn;
    logic [1:0] mosi_ff, nxt_mosi;
    logic [3:0] bit_ff, nxt_bit;
    logic [15:0] rx_sh_ff, nxt_rx_sh;
    logic [15:0] tx_sh_ff, nxt_tx_sh;
    logic miso_ff, nxt_miso;
    logic oe_ff, nxt_oe;
    ssb_pkg::ssb_rx_t rx_ff, nxt_rx;
    logic fall;
    logic rise;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_sclk = {sclk_ff[1:0], sclk};
        nxt_csn = {csn_ff[1:0], csn};
        nxt_mosi = {mosi_ff[0], mosi};
        fall = sclk_ff[2] & ~sclk_ff[1];
        rise = ~sclk_ff[2] & sclk_ff[1];
        nxt_bit = bit_ff;
        nxt_rx_sh = rx_sh_ff;
        nxt_tx_sh = tx_sh_ff;
        nxt_miso = miso_ff;
        nxt_oe = ~csn_ff[1];
        nxt_rx = '0;
        nxt_rx.word = rx_ff.word;
        nxt_rx.cs_low = ~csn_ff[1];
        nxt_rx.cs_rise = csn_ff[1] & ~csn_ff[2];
        nxt_rx.frag = csn_ff[1] & ~csn_ff[2] & (bit_ff != 4'h0); // [R1]
        if (csn_ff[1]) begin
            nxt_bit = 4'h0;
        end else if (fall) begin
            nxt_rx_sh = {rx_sh_ff[14:0], mosi_ff[1]}; // [R2] [R16]
            nxt_bit = bit_ff + 4'h1;
            if (bit_ff == ssb_pkg::BIT_LAST) begin
                nxt_rx.done = 1'b1; // [R1]
                nxt_rx.word = {rx_sh_ff[14:0], mosi_ff[1]};
            end
        end
        if (tx_load) begin
            nxt_tx_sh = tx_word;
        end else if (rise && !csn_ff[1]) begin
            nxt_miso = tx_sh_ff[15]; // [R3] [R16]
            nxt_tx_sh = {tx_sh_ff[14:0], 1'b0};
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sclk_ff <= 3'h0;
            csn_ff <= 3'h7;
            mosi_ff <= 2'h0;
            bit_ff <= 4'h0;
            rx_sh_ff <= 16'h0000;
            tx_sh_ff <= {ssb_pkg::CHECK_PATTERN, 3'b000}; // [R15]
            miso_ff <= 1'b0;
            oe_ff <= 1'b0;
            rx_ff <= '0;
        end else if (ce) begin
            sclk_ff <= nxt_sclk;
            csn_ff <= nxt_csn;
            mosi_ff <= nxt_mosi;
            bit_ff <= nxt_bit;
            rx_sh_ff <= nxt_rx_sh;
            tx_sh_ff <= nxt_tx_sh;
            miso_ff <= nxt_miso;
            oe_ff <= nxt_oe;
            rx_ff <= nxt_rx;
        end
    end

    assign rx = rx_ff;
    assign miso = miso_ff;
    assign miso_oe = oe_ff;
endmodule // ssb_shift

// >>> logic/ssb_slave.sv
// Serial burst slave port: protocol, setup register and watchdog
//
// Contract
// [R1] Slave only, exchanges 16-bit words.
// [R2] Phase 1, polarity 0; MOSI sampled on falling serial clock edge.
// [R3] MISO changes on each rising serial clock edge.
// [R4] Mode bit 0 selects mode A, 1 selects mode B.
// [R5] Interrupt raised on bad transmission when error interrupt enabled.
// [R6] Mode A gap limit is core period times (field+1) times 32768; field resets 01010.
// [R7] Host changes mode with a frame valid in both modes, count nonzero, select held.
// [R8] Mode change is accepted at any moment.
// [R9] After reset and each transfer the next word is a control word.
// [R10] Control word: bit 15 read, bits 14..5 address, bits 4..0 count.
// [R11] Count gives data words in burst, up to 31.
// [R12] Address field is the first address of the burst.
// [R13] Every burst is checked using the checks of the current mode.
// [R14] Read frame 2 to 32 words; read word k returned during frame word k+1.
// [R15] Command word answer: check pattern in 15..3, clock, frame, word flags below; the clock flag (bit 2) is always sent as 0.
// [R16] Every word is shifted most significant bit first.
// [R17] Mode A gap beyond watchdog time enters the error state.
// [R18] Host never sends zero count with nonzero address.
// [R19] Address steps up by one per data word.
// [R20] Back to control word once count words are transferred.
`timescale 1ns/100ps
module ssb_slave #(
    parameter int WD_UNIT = ssb_pkg::WD_UNIT_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic sclk,
    input wire logic csn,
    input wire logic mosi,
    output logic miso,
    output logic miso_oe,
    output logic [9:0] mem_addr,
    output logic [15:0] mem_wdata,
    output logic mem_we,
    output logic mem_re,
    input wire logic [15:0] mem_rdata,
    output logic irq,
    output logic mode_b,
    output logic miso_slew
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] status_word(input logic frame_e, input logic word_e);
        status_word = {ssb_pkg::CHECK_PATTERN, 1'b0, frame_e, word_e}; // [R15]
    endfunction

    function automatic logic [20:0] wd_limit(input logic [4:0] field);
        logic [31:0] prod;
        prod = (32'(field) + 32'd1) * 32'(WD_UNIT); // [R6]
        wd_limit = prod[20:0];
    endfunction

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    ssb_pkg::ssb_rx_t rx;
    ssb_pkg::ssb_state_t st_ff, nxt_st;
    logic [9:0] addr_ff, nxt_addr;
    logic [4:0] left_ff, nxt_left;
    logic rd_ff, nxt_rd;
    logic [15:0] wdata_ff, nxt_wdata;
    logic we_ff, nxt_we;
    logic re_ff, nxt_re;
    logic [15:0] setup_ff, nxt_setup;
    logic frame_err_ff, nxt_frame_err;
    logic word_err_ff, nxt_word_err;
    logic irq_ff, nxt_irq;
    logic [20:0] wd_ff, nxt_wd;
    logic tx_load;
    logic [15:0] tx_word;
    logic set_frame;
    logic set_word;
    logic clr_flags;

    // ------------------------------------------------------------
    // Pin side
    // ------------------------------------------------------------
    ssb_shift u_shift (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .ce(ce),
        .sclk(sclk),
        .csn(csn),
        .mosi(mosi),
        .tx_load(tx_load),
        .tx_word(tx_word),
        .rx(rx),
        .miso(miso),
        .miso_oe(miso_oe)
    );

    // ------------------------------------------------------------
    // Protocol next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_addr = addr_ff;
        nxt_left = left_ff;
        nxt_rd = rd_ff;
        nxt_wdata = wdata_ff;
        nxt_we = 1'b0;
        nxt_re = 1'b0;
        nxt_setup = setup_ff;
        nxt_wd = wd_ff;
        tx_load = 1'b0;
        tx_word = status_word(frame_err_ff, word_err_ff);
        set_frame = 1'b0;
        set_word = rx.frag;
        clr_flags = 1'b0;
        case (st_ff)
            ssb_pkg::ST_IDLE: begin
                nxt_wd = 21'h0;
                if (rx.done) begin
                    nxt_rd = rx.word[ssb_pkg::CTRL_RW_BIT]; // [R10]
                    nxt_addr = rx.word[ssb_pkg::CTRL_ADDR_MSB:ssb_pkg::CTRL_ADDR_LSB]; // [R12]
                    nxt_left = rx.word[ssb_pkg::CTRL_CNT_MSB:ssb_pkg::CTRL_CNT_LSB]; // [R11]
                    clr_flags = 1'b1;
                    if (rx.word[ssb_pkg::CTRL_CNT_MSB:ssb_pkg::CTRL_CNT_LSB] == 5'h0) begin
                        tx_load = 1'b1; // [R9]
                    end else if (rx.word[ssb_pkg::CTRL_RW_BIT]) begin
                        nxt_re = (nxt_addr != ssb_pkg::SETUP_ADDR);
                        nxt_st = ssb_pkg::ST_FETCH; // [R14]
                    end else begin
                        nxt_st = ssb_pkg::ST_DATA;
                        tx_load = 1'b1;
                    end
                end
            end
            ssb_pkg::ST_FETCH: begin
                nxt_st = ssb_pkg::ST_LOAD;
            end
            ssb_pkg::ST_LOAD: begin
                tx_load = 1'b1; // [R14]
                tx_word = (addr_ff == ssb_pkg::SETUP_ADDR) ? setup_ff : mem_rdata;
                nxt_st = ssb_pkg::ST_DATA;
            end
            ssb_pkg::ST_DATA: begin
                if (rx.done) begin
                    nxt_wd = 21'h0;
                    nxt_left = left_ff - 5'h1;
                    if (!rd_ff) begin
                        if (addr_ff == ssb_pkg::SETUP_ADDR) begin
                            nxt_setup = rx.word & ssb_pkg::SETUP_MASK; // [R4] [R8]
                        end else begin
                            nxt_we = 1'b1;
                            nxt_wdata = rx.word;
                        end
                    end
                    nxt_addr = addr_ff + 10'h1; // [R19]
                    if (left_ff == 5'h1) begin
                        nxt_st = ssb_pkg::ST_IDLE; // [R20]
                        tx_load = 1'b1;
                    end else if (rd_ff) begin
                        nxt_re = (nxt_addr != ssb_pkg::SETUP_ADDR); // [R19]
                        nxt_st = ssb_pkg::ST_FETCH;
                    end else begin
                        tx_load = 1'b1;
                    end
                end else if (setup_ff[ssb_pkg::SETUP_MODE_BIT] == ssb_pkg::MODE_B) begin
                    nxt_wd = 21'h0;
                    if (rx.cs_rise) begin
                        set_frame = 1'b1; // [R13]
                        nxt_st = ssb_pkg::ST_IDLE;
                        tx_load = 1'b1;
                    end
                end else begin
                    if (!rx.cs_low) begin
                        nxt_wd = wd_ff + 21'h1;
                    end
                    if (wd_ff >= wd_limit(setup_ff[ssb_pkg::SETUP_WD_MSB:ssb_pkg::SETUP_WD_LSB])) begin
                        set_frame = 1'b1; // [R6] [R13] [R17]
                        nxt_st = ssb_pkg::ST_IDLE;
                        tx_load = 1'b1;
                        nxt_wd = 21'h0;
                    end
                end
            end
            default: begin
                nxt_st = ssb_pkg::ST_IDLE;
            end
        endcase
        if (set_frame || set_word) begin
            tx_load = 1'b1; // [R15]
            tx_word = status_word(frame_err_ff | set_frame, word_err_ff | set_word);
        end
        if (clr_flags) begin
            tx_word = status_word(set_frame, set_word);
        end
        nxt_frame_err = set_frame | (frame_err_ff & ~clr_flags);
        nxt_word_err = set_word | (word_err_ff & ~clr_flags);
        nxt_irq = setup_ff[ssb_pkg::SETUP_IRQEN_BIT] & (nxt_frame_err | nxt_word_err); // [R5]
    end

    // ------------------------------------------------------------
    // Protocol registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st_ff <= ssb_pkg::ST_IDLE; // [R9]
            addr_ff <= 10'h0;
            left_ff <= 5'h0;
            rd_ff <= 1'b0;
            wdata_ff <= 16'h0000;
            we_ff <= 1'b0;
            re_ff <= 1'b0;
            setup_ff <= ssb_pkg::SETUP_RESET; // [R6]
            frame_err_ff <= 1'b0;
            word_err_ff <= 1'b0;
            irq_ff <= 1'b0;
            wd_ff <= 21'h0;
        end else if (ce) begin
            st_ff <= nxt_st;
            addr_ff <= nxt_addr;
            left_ff <= nxt_left;
            rd_ff <= nxt_rd;
            wdata_ff <= nxt_wdata;
            we_ff <= nxt_we;
            re_ff <= nxt_re;
            setup_ff <= nxt_setup;
            frame_err_ff <= nxt_frame_err;
            word_err_ff <= nxt_word_err;
            irq_ff <= nxt_irq;
            wd_ff <= nxt_wd;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    logic [9:0] mem_addr_ff, nxt_mem_addr;

    always_comb begin
        nxt_mem_addr = nxt_re ? nxt_addr : (nxt_we ? addr_ff : mem_addr_ff);
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            mem_addr_ff <= 10'h0;
        end else if (ce) begin
            mem_addr_ff <= nxt_mem_addr;
        end
    end

    assign mem_addr = mem_addr_ff;
    assign mem_wdata = wdata_ff;
    assign mem_we = we_ff;
    assign mem_re = re_ff;
    assign irq = irq_ff;
    assign mode_b = setup_ff[ssb_pkg::SETUP_MODE_BIT];
    assign miso_slew = setup_ff[ssb_pkg::SETUP_SLEW_BIT];
endmodule // ssb_slave

// >>> testbench/ssb_host_model.sv
// Host serial master model driving the burst slave port
`timescale 1ns/100ps
module ssb_host_model (
    input wire logic ref_clk,
    input wire logic miso,
    output logic sclk,
    output logic csn,
    output logic mosi
);
    initial begin
        sclk = 1'b0;
        csn = 1'b1;
        mosi = 1'b0;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // Select held low for a whole frame, data line inverted when high
    task automatic select(input logic lvl);
        wait_clk(4);
        csn <= lvl;
        if (lvl) begin
            mosi <= ~mosi;
        end
        wait_clk(4);
    endtask
    // Clock idles low, data changes on rise, MSB first
    task automatic shift(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
        rx = 16'h0000;
        for (int i = 15; i > 15 - nbits; i--) begin
            sclk <= 1'b1;
            mosi <= tx[i];
            wait_clk(4);
            sclk <= 1'b0;
            wait_clk(4);
            rx[i] = miso;
        end
    endtask
endmodule // ssb_host_model

// >>> testbench/ssb_slave_sva.sv
// Port checker of the serial burst slave port
`timescale 1ns/100ps
module ssb_slave_sva (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic csn,
    input wire logic miso_oe,
    input wire logic mem_we,
    input wire logic mem_re,
    input wire logic irq,
    input wire logic mode_b,
    input wire logic miso_slew
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn || !ce);
    property p_oe_on;
        $fell(csn) |-> ##[1:4] miso_oe;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("miso enable late");
    property p_oe_off;
        $rose(csn) |-> ##[1:4] !miso_oe;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("miso enable stuck");
    property p_idle;
        csn [*8] |-> !mem_we && !mem_re;
    endproperty
    a_idle: assert property (p_idle) else $error("access while deselected");
    property p_we_pulse;
        mem_we |=> !mem_we;
    endproperty
    a_we_pulse: assert property (p_we_pulse) else $error("write pulse too long");
    property p_re_pulse;
        mem_re |=> !mem_re;
    endproperty
    a_re_pulse: assert property (p_re_pulse) else $error("read pulse too long");
    property p_setup;
        $changed(mode_b) || $changed(miso_slew) |-> !$past(csn, 3);
    endproperty
    a_setup: assert property (p_setup) else $error("setup changed without frame");
    property p_irq_rise;
        $rose(irq) |-> $past(csn, 2);
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq without bad transfer");
    property p_irq_fall;
        $fell(irq) |-> !$past(csn, 3);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq cleared outside frame");
endmodule // ssb_slave_sva

bind ssb_slave ssb_slave_sva u_sva (.ref_clk(ref_clk), .rstn(rstn), .ce(ce), .csn(csn),
    .miso_oe(miso_oe), .mem_we(mem_we), .mem_re(mem_re), .irq(irq), .mode_b(mode_b),
    .miso_slew(miso_slew));

// >>> testbench/ssb_slave_tb_top.sv
// Self-checking bench of the serial burst slave port
`timescale 1ns/100ps
module ssb_slave_tb_top;
    localparam int WDU = 4;
    logic ref_clk, rstn, ce, sclk, csn, mosi, miso, miso_oe;
    logic mem_we, mem_re, irq, mode_b, miso_slew;
    logic [9:0] mem_addr;
    logic [15:0] mem_wdata, mem_rdata, rx;
    logic [15:0] txw[0:3];
    logic [15:0] rxw[0:3];
    logic [9:0] wr_addr[$];
    logic [15:0] wr_data[$];
    int mismatches, checks_done;
    // ------------------------------------------------------------
    // Design, host and memory
    // ------------------------------------------------------------
    ssb_slave #(.WD_UNIT(WDU)) dut (.ref_clk(ref_clk), .rstn(rstn), .ce(ce), .sclk(sclk),
        .csn(csn), .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata),
        .irq(irq), .mode_b(mode_b), .miso_slew(miso_slew));
    ssb_host_model host (.ref_clk(ref_clk), .miso(miso), .sclk(sclk), .csn(csn), .mosi(mosi));
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    function automatic logic [15:0] rd_val(input logic [9:0] a);
        return {a, 6'h15};
    endfunction
    function automatic logic [15:0] ctl(input logic rd, input logic [9:0] a, input logic [4:0] n);
        return {rd, a, n};
    endfunction
    always @(posedge ref_clk) begin
        mem_rdata <= mem_re ? rd_val(mem_addr) : ~mem_rdata;
        if (mem_we === 1'b1) begin
            wr_addr.push_back(mem_addr);
            wr_data.push_back(mem_wdata);
        end
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic frame(input int n);
        host.select(1'b0);
        for (int k = 0; k < n; k++) begin
            host.shift(txw[k], 16, rxw[k]);
        end
        host.select(1'b1);
    endtask
    task automatic setup_wr(input logic [15:0] v);
        txw[0] = ctl(1'b0, ssb_pkg::SETUP_ADDR, 5'h01);
        txw[1] = v;
        frame(2);
    endtask
    task automatic setup_rd;
        txw[0] = ctl(1'b1, ssb_pkg::SETUP_ADDR, 5'h01);
        txw[1] = 16'h0000;
        frame(2);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge ref_clk);
        mismatches++;
        end_sim;
    end
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        ce = 1'b1;
        mismatches = 0;
        checks_done = 0;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (2) @(posedge ref_clk);
        check("reset outputs", 16'h0000, {miso_oe, irq, mode_b, miso_slew});
        setup_rd;
        check("first answer", 16'haaa8, rxw[0]);
        check("setup reset", 16'h000a, rxw[1]);
        $display("test reset done");
        txw[0] = ctl(1'b0, 10'h010, 5'h03);
        txw[1] = 16'h1234;
        txw[2] = 16'habcd;
        txw[3] = 16'h0f0f;
        frame(4);
        repeat (8) @(posedge ref_clk);
        check("write answer", 16'haaa8, rxw[0]);
        check("write count", 16'h0003, 16'(wr_addr.size()));
        for (int k = 0; k < 3; k++) begin
            check("write addr", 16'h0010 + 16'(k), 16'(wr_addr[k]));
            check("write data", txw[k + 1], wr_data[k]);
        end
        $display("test write burst done");
        txw[0] = ctl(1'b1, 10'h3f0, 5'h02);
        txw[1] = 16'h0000;
        txw[2] = 16'h0000;
        frame(3);
        check("read word 1", rd_val(10'h3f0), rxw[1]);
        check("read word 2", rd_val(10'h3f1), rxw[2]);
        $display("test read burst done");
        setup_wr(16'hffa3);
        check("setup outputs", 16'h0001, {mode_b, miso_slew});
        setup_rd;
        check("setup readback", 16'h00a3, rxw[1]);
        $display("test setup done");
        host.select(1'b0);
        host.shift(16'h8421, 8, rx);
        host.select(1'b1);
        repeat (4) @(posedge ref_clk);
        check("irq word error", 16'h0001, irq);
        setup_rd;
        check("irq cleared", 16'h0000, irq);
        check("word error answer", 16'haaa9, rxw[0]);
        $display("test word error done");
        wr_addr.delete();
        for (int g = 0; g < 2; g++) begin
            host.select(1'b0);
            host.shift(ctl(1'b0, 10'h040, 5'h02), 16, rx);
            host.shift(16'h5a5a, 16, rx);
            host.select(1'b1);
            repeat (g * 40) @(posedge ref_clk);
            if (g == 0) begin
                host.select(1'b0);
                host.shift(16'hc3c3, 16, rx);
                host.select(1'b1);
            end
            check("irq gap", 16'(g), irq);
        end
        check("gap writes", 16'h0003, 16'(wr_addr.size()));
        $display("test watchdog done");
        setup_wr(16'h0063);
        check("gap answer", 16'haaaa, rxw[0]);
        check("mode b", 16'h0001, mode_b);
        host.select(1'b0);
        host.shift(ctl(1'b0, 10'h050, 5'h02), 16, rx);
        host.shift(16'h1111, 16, rx);
        host.select(1'b1);
        repeat (4) @(posedge ref_clk);
        check("irq mode b", 16'h0001, irq);
        $display("test mode b done");
        ce <= 1'b0;
        setup_wr(16'h0000);
        ce <= 1'b1;
        check("frozen outputs", 16'h0003, {mode_b, irq});
        setup_rd;
        check("frozen answer", 16'haaaa, rxw[0]);
        check("frozen setup", 16'h0063, rxw[1]);
        $display("test clock enable done");
        end_sim;
    end
endmodule // ssb_slave_tb_top
